// >>> epm_defs.svh
`ifndef EPM_DEFS_SVH
`define EPM_DEFS_SVH
// i/o base addresses selected by the port-select pin
`define EPM_BASE_LOW        10'h0_0E8
`define EPM_BASE_HIGH       10'h0_098
// register indices within the eight-byte block
`define EPM_IDX_PORT        3'h0
`define EPM_IDX_RSVD        3'h1
`define EPM_IDX_SYSMEM      3'h2
`define EPM_IDX_WINDOW      3'h3
`define EPM_IDX_BANK0       3'h4
// field positions
`define EPM_BIT_FLAG        7
`define EPM_SEG_MSB         7
`define EPM_SEG_LSB         2
// reset values
`define EPM_RST_BYTE        8'h00
// wrap point of page numbers in a 1MB configuration
`define EPM_WRAP_PAGE       8'h40
`define EPM_WRAP_MASK       8'h3F
// largest page number served with 4MB of dram
`define EPM_MAX_PAGES       216
// cycles the copy from staged to active mapping takes
`define EPM_COPY_CYCLES     4
`endif

// >>> epm_pkg.sv
package epm_pkg;
   typedef enum logic [2:0]
   {
      EPM_ST_UNCFG = 3'b001,
      EPM_ST_IDLE  = 3'b010,
      EPM_ST_COPY  = 3'b100
   } epm_state_t;
   typedef logic [7:0] epm_byte_t;
endpackage : epm_pkg

// >>> epm_map_if.sv
`timescale 1ns/100ps
interface epm_map_if;
   logic [7:0] sysmem;
   logic [7:0] window;
   logic [7:0] page [4];
   logic       copy_go;
   logic       copy_busy;
   modport ctrl (output sysmem, output window, output page, output copy_go, input copy_busy);
   modport map  (input sysmem, input window, input page, input copy_go, output copy_busy);
endinterface : epm_map_if

// >>> epm_decode.sv
`timescale 1ns/100ps
`include "epm_defs.svh"
// matches an i/o address against the selected base
module epm_decode
(
   input  wire logic [9:0] io_addr_i,
   input  wire logic       port_base_select_i,
   output logic            hit_o,
   output logic [2:0]      idx_o
);
   logic [9:0] base;
   always_comb
   begin
      base  = port_base_select_i ? `EPM_BASE_HIGH : `EPM_BASE_LOW;
      hit_o = (io_addr_i[9:3] == base[9:3]);
      idx_o = io_addr_i[2:0];
   end
endmodule : epm_decode

// >>> epm_active_map.sv
`timescale 1ns/100ps
`include "epm_defs.svh"
// active mapping: takes staged window and page values after a fixed copy delay
module epm_active_map
#(
   parameter int COPY_CYCLES = `EPM_COPY_CYCLES
)
(
   input  wire logic ref_clk_i,
   input  wire logic nrst_i,
   input  wire logic ce_i,
   input  wire logic mem_1mb_i,
   epm_map_if.map    mp,
   output logic [7:0] act_window_o,
   output logic [7:0] act_page_o [4],
   output logic [3:0] act_valid_o
);
   if (COPY_CYCLES < 1 || COPY_CYCLES > 255)
   begin : g_bad_copy
      $error("copy cycles out of range");
   end
   logic [7:0] cnt_ff,  nxt_cnt;
   logic [7:0] win_ff,  nxt_win;
   logic [7:0] pg_ff [4];
   logic [7:0] nxt_pg [4];
   logic [3:0] val_ff,  nxt_val;
   always_comb
   begin
      nxt_cnt = cnt_ff;
      nxt_win = win_ff;
      nxt_val = val_ff;
      for (int i = 0; i < 4; i++)
         nxt_pg[i] = pg_ff[i];
      if (mp.copy_go)
         nxt_cnt = 8'(COPY_CYCLES);
      else if (cnt_ff != 8'h00)
      begin
         nxt_cnt = cnt_ff - 8'h01;
         if (cnt_ff == 8'h01)
         begin
            nxt_win = mp.window;
            for (int i = 0; i < 4; i++)
            begin
               // bank i drives physical page i only
               nxt_pg[i]  = (mem_1mb_i && mp.page[i] >= `EPM_WRAP_PAGE) ?
                            (mp.page[i] & `EPM_WRAP_MASK) : mp.page[i];
               nxt_val[i] = (mp.page[i] != 8'h00) &&
                            (mp.page[i] <= 8'(`EPM_MAX_PAGES));
            end
         end
      end
   end
   always_ff @(posedge ref_clk_i)
   begin
      if (!nrst_i)
      begin
         cnt_ff <= 8'h00;
         win_ff <= `EPM_RST_BYTE;
         val_ff <= 4'h0;
         for (int i = 0; i < 4; i++)
            pg_ff[i] <= `EPM_RST_BYTE;
      end
      else if (ce_i)
      begin
         cnt_ff <= nxt_cnt;
         win_ff <= nxt_win;
         val_ff <= nxt_val;
         for (int i = 0; i < 4; i++)
            pg_ff[i] <= nxt_pg[i];
      end
   end
   assign mp.copy_busy = (cnt_ff != 8'h00) || mp.copy_go;
   assign act_window_o = win_ff;
   assign act_page_o   = pg_ff;
   assign act_valid_o  = val_ff;
endmodule : epm_active_map

// >>> epm_page_mapper.sv
`timescale 1ns/100ps
`include "epm_defs.svh"
//
// Behaviour
// - staged window and bank values copy to active mapping; port register bit 7 shows pending
// - port register write: bit 7 readback enable, bits 6-0 address bits 9-3
// - bank registers hold 8-bit page numbers in 16KB units, readable when readback is enabled
// - page number zero releases that physical page
// - bank registers 0-3 map fixed to physical pages 0-3
// - in 1MB configuration page 40H wraps to dram address zero
// - at most 216 expanded pages are supported
// - port-select low gives E8H-EFH, high gives 98H-9FH
// - eight registers sit at consecutive i/o addresses from the base
module epm_page_mapper
(
   input  wire logic       ref_clk_i,
   input  wire logic       nrst_i,
   input  wire logic       ce_i,
   input  wire logic       port_base_select_i,
   input  wire logic       mem_1mb_i,
   input  wire logic [9:0] io_addr_i,
   input  wire logic       io_wr_i,
   input  wire logic       io_rd_i,
   input  wire logic [7:0] io_wdata_i,
   output logic      [7:0] io_rdata_o,
   output logic            io_rdata_oe_o,
   output logic            configured_o,
   output logic      [7:0] act_window_o,
   output logic      [7:0] act_page0_o,
   output logic      [7:0] act_page1_o,
   output logic      [7:0] act_page2_o,
   output logic      [7:0] act_page3_o,
   output logic      [3:0] act_valid_o
);
   //--------------------------------------------------------------
   // decode and staging
   //--------------------------------------------------------------
   logic                  hit;
   logic [2:0]            idx;
   epm_pkg::epm_state_t   st_ff, nxt_st;
   logic                  rden_ff, nxt_rden;
   logic [6:0]            pbase_ff, nxt_pbase;
   logic [7:0]            stg_ff [8];
   logic [7:0]            nxt_stg [8];
   logic                  go_ff, nxt_go;
   logic [7:0]            rd_ff, nxt_rd;
   logic                  oe_ff, nxt_oe;
   logic                  cfg_ff, nxt_cfg;
   logic                  busy;
   logic [7:0]            apg [4];
   logic [7:0]            win;
   logic [3:0]            val;
   logic [7:0]            w_ff [4];
   logic [7:0]            wwin_ff;
   logic [3:0]            wval_ff;
   epm_map_if             mif ();
   epm_decode u_dec
   (
      .io_addr_i          (io_addr_i),
      .port_base_select_i (port_base_select_i),
      .hit_o              (hit),
      .idx_o              (idx)
   );
   epm_active_map #(.COPY_CYCLES(`EPM_COPY_CYCLES)) u_map
   (
      .ref_clk_i    (ref_clk_i),
      .nrst_i       (nrst_i),
      .ce_i         (ce_i),
      .mem_1mb_i    (mem_1mb_i),
      .mp           (mif),
      .act_window_o (win),
      .act_page_o   (apg),
      .act_valid_o  (val)
   );
   assign mif.sysmem  = stg_ff[`EPM_IDX_SYSMEM];
   assign mif.window  = stg_ff[`EPM_IDX_WINDOW];
   assign mif.copy_go = go_ff;
   assign busy        = mif.copy_busy;
   generate
      for (genvar g = 0; g < 4; g++)
      begin : g_pg
         assign mif.page[g] = stg_ff[4 + g];
      end
   endgenerate
   //--------------------------------------------------------------
   // next-state logic
   //--------------------------------------------------------------
   always_comb
   begin
      nxt_st    = st_ff;
      nxt_rden  = rden_ff;
      nxt_pbase = pbase_ff;
      nxt_go    = 1'b0;
      nxt_rd    = 8'h00;
      nxt_oe    = 1'b0;
      for (int i = 0; i < 8; i++)
         nxt_stg[i] = stg_ff[i];
      if (hit && io_wr_i)
      begin
         if (idx == `EPM_IDX_PORT)
         begin
            nxt_rden  = io_wdata_i[`EPM_BIT_FLAG];
            nxt_pbase = io_wdata_i[6:0];
            if (st_ff == epm_pkg::EPM_ST_UNCFG)
               nxt_st = epm_pkg::EPM_ST_IDLE;
         end
         else if (idx == `EPM_IDX_RSVD)
         begin
            nxt_go = 1'b0;
         end
         else if (st_ff != epm_pkg::EPM_ST_UNCFG)
         begin
            if (idx == `EPM_IDX_SYSMEM || idx == `EPM_IDX_WINDOW)
               nxt_stg[idx] = {io_wdata_i[`EPM_SEG_MSB:`EPM_SEG_LSB], 2'b00};
            else
               nxt_stg[idx] = io_wdata_i;
            nxt_go = 1'b1;
            nxt_st = epm_pkg::EPM_ST_COPY;
         end
      end
      else if (st_ff == epm_pkg::EPM_ST_COPY && !busy && !go_ff)
         nxt_st = epm_pkg::EPM_ST_IDLE;
      if (hit && io_rd_i)
      begin
         if (idx == `EPM_IDX_PORT)
         begin
            nxt_rd = {(busy || go_ff), pbase_ff};
            nxt_oe = 1'b1;
         end
         else if (idx != `EPM_IDX_RSVD && rden_ff)
         begin
            nxt_rd = stg_ff[idx];
            nxt_oe = 1'b1;
         end
         else
            nxt_oe = 1'b0;
      end
      nxt_cfg = (nxt_st != epm_pkg::EPM_ST_UNCFG);
   end
   //--------------------------------------------------------------
   // registers
   //--------------------------------------------------------------
   always_ff @(posedge ref_clk_i)
   begin
      if (!nrst_i)
      begin
         st_ff    <= epm_pkg::EPM_ST_UNCFG;
         rden_ff  <= 1'b0;
         pbase_ff <= 7'h00;
         go_ff    <= 1'b0;
         rd_ff    <= 8'h00;
         oe_ff    <= 1'b0;
         cfg_ff   <= 1'b0;
         wwin_ff  <= 8'h00;
         wval_ff  <= 4'h0;
         for (int i = 0; i < 8; i++)
            stg_ff[i] <= `EPM_RST_BYTE;
         for (int i = 0; i < 4; i++)
            w_ff[i] <= 8'h00;
      end
      else if (ce_i)
      begin
         st_ff    <= nxt_st;
         rden_ff  <= nxt_rden;
         pbase_ff <= nxt_pbase;
         go_ff    <= nxt_go;
         rd_ff    <= nxt_rd;
         oe_ff    <= nxt_oe;
         cfg_ff   <= nxt_cfg;
         wwin_ff  <= win;
         wval_ff  <= val;
         for (int i = 0; i < 8; i++)
            stg_ff[i] <= nxt_stg[i];
         for (int i = 0; i < 4; i++)
            w_ff[i] <= apg[i];
      end
   end
   //--------------------------------------------------------------
   // outputs
   //--------------------------------------------------------------
   assign io_rdata_o    = rd_ff;
   assign io_rdata_oe_o = oe_ff;
   assign configured_o  = cfg_ff;
   assign act_window_o  = wwin_ff;
   assign act_page0_o   = w_ff[0];
   assign act_page1_o   = w_ff[1];
   assign act_page2_o   = w_ff[2];
   assign act_page3_o   = w_ff[3];
   assign act_valid_o   = wval_ff;
endmodule : epm_page_mapper

// >>> epm_mapper_monitor.sv
`timescale 1ns/100ps
`include "epm_defs.svh"
module epm_mapper_monitor
(
   input  wire logic       ref_clk_i,
   input  wire logic       nrst_i,
   input  wire logic       ce_i,
   input  wire logic       port_base_select_i,
   input  wire logic       mem_1mb_i,
   input  wire logic [9:0] io_addr_i,
   input  wire logic       io_wr_i,
   input  wire logic       io_rd_i,
   input  wire logic [7:0] io_wdata_i,
   input  wire logic [7:0] io_rdata_o,
   input  wire logic       io_rdata_oe_o,
   input  wire logic       configured_o,
   input  wire logic [7:0] act_page0_o,
   input  wire logic [3:0] act_valid_o
);
   logic [9:0] base;
   logic [2:0] off;
   logic       hit, rd, wr;
   logic [7:0] port_ff, pg_ff;
   assign base = port_base_select_i ? `EPM_BASE_HIGH : `EPM_BASE_LOW;
   assign hit = io_addr_i >= base && io_addr_i <= base + 10'h007;
   assign off = 3'(io_addr_i - base);
   assign rd = io_rd_i && ce_i && hit;
   assign wr = io_wr_i && ce_i && hit;
   // last port byte and last bank zero byte seen on the bus
   always_ff @(posedge ref_clk_i)
   begin
      if (!nrst_i)
         port_ff <= 8'h00;
      else if (wr && off == 3'h0)
         port_ff <= io_wdata_i;
      if (wr && off == 3'h4)
         pg_ff <= io_wdata_i;
   end
   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (!nrst_i);
   oe_cause_a: assert property (io_rdata_oe_o |-> $past(io_rd_i && ce_i))
      else $error("bus driven without a read");
   rd_port_a: assert property (rd && off == 3'h0 && configured_o |=> io_rdata_oe_o && io_rdata_o[6:0] == port_ff[6:0])
      else $error("port register read wrong");
   rsvd_rd_a: assert property (rd && off == 3'h1 |=> !io_rdata_oe_o)
      else $error("reserved read drove bus");
   miss_rd_a: assert property (io_rd_i && !hit |=> !io_rdata_oe_o)
      else $error("foreign address drove bus");
   rb_off_a: assert property (rd && off >= 3'h2 && !port_ff[7] |=> !io_rdata_oe_o)
      else $error("readback off but bus driven");
   cfg_set_a: assert property (wr && off == 3'h0 |=> configured_o)
      else $error("not configured after port write");
   uncfg_map_a: assert property (!configured_o |-> act_valid_o == 4'h0)
      else $error("mapping active while unconfigured");
   page_zero_a: assert property (act_valid_o[0] && !mem_1mb_i |-> act_page0_o != 8'h00)
      else $error("page zero still mapped");
   copy_done_a: assert property (wr && off == 3'h4 && configured_o && !mem_1mb_i && io_wdata_i != 8'h00
      && io_wdata_i <= 8'hD8 |-> ##[2:30] act_valid_o[0] && act_page0_o == pg_ff)
      else $error("bank zero not copied");
endmodule : epm_mapper_monitor
bind epm_page_mapper epm_mapper_monitor u_mon
(
   .ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .ce_i(ce_i), .port_base_select_i(port_base_select_i),
   .mem_1mb_i(mem_1mb_i), .io_addr_i(io_addr_i), .io_wr_i(io_wr_i), .io_rd_i(io_rd_i),
   .io_wdata_i(io_wdata_i), .io_rdata_o(io_rdata_o), .io_rdata_oe_o(io_rdata_oe_o),
   .configured_o(configured_o), .act_page0_o(act_page0_o), .act_valid_o(act_valid_o)
);

// >>> epm_host_model.sv
`timescale 1ns/100ps
`include "epm_defs.svh"
// host side of the i/o bus: one-cycle strobes, bus scrambled when idle
module epm_host_model
(
   input  wire logic       ref_clk_i,
   input  wire logic       port_base_select_i,
   input  wire logic [7:0] io_rdata_i,
   input  wire logic       io_rdata_oe_i,
   output logic      [9:0] io_addr_o,
   output logic            io_wr_o,
   output logic            io_rd_o,
   output logic      [7:0] io_wdata_o
);
   logic [9:0] base;
   assign base = port_base_select_i ? `EPM_BASE_HIGH : `EPM_BASE_LOW;
   initial
   begin
      io_addr_o = 10'h3FF;
      io_wr_o = 1'b0;
      io_rd_o = 1'b0;
      io_wdata_o = 8'h00;
   end
   task automatic acc(input logic rd, input logic [9:0] a, input logic [7:0] d, output logic [7:0] q,
                      output logic oe);
      @(posedge ref_clk_i);
      io_addr_o <= a;
      io_wdata_o <= d;
      io_wr_o <= !rd;
      io_rd_o <= rd;
      @(posedge ref_clk_i);
      io_wr_o <= 1'b0;
      io_rd_o <= 1'b0;
      io_addr_o <= ~a;
      io_wdata_o <= ~d;
      @(negedge ref_clk_i);
      q = io_rdata_i;
      oe = io_rdata_oe_i;
   endtask : acc
   task automatic init();
      logic [7:0] q;
      logic       oe;
      acc(1'b0, base, port_base_select_i ? 8'h93 : 8'h9D, q, oe);
   endtask : init
endmodule : epm_host_model

// >>> tb_top.sv
`timescale 1ns/100ps
`define CHK(n, e, g) begin compares++; if ((e) !== (g)) begin miscompares++; \
   $display("unexpected %s exp %h got %h", n, e, g); end end
module tb_top;
   logic       ref_clk_i = 1'b0;
   logic       nrst_i = 1'b0;
   logic       sel = 1'b0;
   logic       m1 = 1'b0;
   logic       ce = 1'b1;
   logic [9:0] a;
   logic       wr, rd, oe, cfg, qo;
   logic [7:0] wd, rdat, win, q, pg [4];
   logic [3:0] vld;
   logic [7:0] ed [4] = '{8'h00, 8'hD8, 8'h40, 8'hD9};
   logic [9:0] ro [4] = '{10'h001, 10'h002, 10'h005, 10'h008};
   int         miscompares = 0, compares = 0, m_pg [4], t, s2, s3;
   always #10 ref_clk_i = ~ref_clk_i;
   epm_host_model h (.ref_clk_i(ref_clk_i), .port_base_select_i(sel), .io_rdata_i(rdat), .io_rdata_oe_i(oe),
      .io_addr_o(a), .io_wr_o(wr), .io_rd_o(rd), .io_wdata_o(wd));
   epm_page_mapper dut (.ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .ce_i(ce), .port_base_select_i(sel),
      .mem_1mb_i(m1), .io_addr_i(a), .io_wr_i(wr), .io_rd_i(rd), .io_wdata_i(wd), .io_rdata_o(rdat),
      .io_rdata_oe_o(oe), .configured_o(cfg), .act_window_o(win), .act_page0_o(pg[0]),
      .act_page1_o(pg[1]), .act_page2_o(pg[2]), .act_page3_o(pg[3]), .act_valid_o(vld));
   task automatic print_verdict();
      $display("compares %0d miscompares %0d", compares, miscompares);
      if (miscompares == 0 && compares > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : print_verdict
   task automatic do_reset(input logic s);
      @(posedge ref_clk_i);
      nrst_i <= 1'b0;
      sel <= s;
      m1 <= 1'b0;
      repeat (20) @(posedge ref_clk_i);
      nrst_i <= 1'b1;
      m_pg = '{0, 0, 0, 0};
   endtask : do_reset
   task automatic wr_reg(input int o, input int d);
      h.acc(1'b0, h.base + 10'(o), 8'(d), q, qo);
      if (o > 3)
         m_pg[o - 4] = d;
   endtask : wr_reg
   task automatic rd_chk(input int o, input int e);
      h.acc(1'b1, h.base + 10'(o), 8'h00, q, qo);
      `CHK("rb_oe", 1'b1, qo)
      `CHK("rb_data", 8'(e), q)
   endtask : rd_chk
   // ----------------------------------------------------------------
   // poll the transfer flag, then compare the active mapping
   // ----------------------------------------------------------------
   task automatic settle();
      int p;
      h.acc(1'b1, h.base, 8'h00, q, qo);
      `CHK("pending", 1'b1, q[7])
      `CHK("port_bits", h.base[9:3], q[6:0])
      for (t = 0; t < 20 && q[7] !== 1'b0; t++)
         h.acc(1'b1, h.base, 8'h00, q, qo);
      `CHK("done", 1'b0, q[7])
      repeat (3) @(posedge ref_clk_i);
      for (int k = 0; k < 4; k++)
      begin
         p = (m1 && m_pg[k] >= 8'h40) ? m_pg[k] & 8'h3F : m_pg[k];
         `CHK("valid", (m_pg[k] != 0 && m_pg[k] <= 8'hD8), vld[k])
         if (m_pg[k] != 0 && m_pg[k] <= 8'hD8)
            `CHK("page", p[7:0], pg[k])
      end
   endtask : settle
   initial
   begin
      repeat (20000) @(posedge ref_clk_i);
      miscompares++;
      print_verdict();
   end
   initial
   begin
      void'($urandom(47));
      do_reset(1'b0);
      h.acc(1'b0, h.base + 10'h004, 8'h28, q, qo);
      `CHK("cfg", 1'b0, cfg)
      h.init();
      `CHK("cfg", 1'b1, cfg)
      for (int n = 0; n < 2; n++)
      begin
         s2 = $urandom_range(8'hA0);
         s3 = $urandom_range(8'hFF, s2);
         wr_reg(2, s2);
         wr_reg(3, s3);
         for (int k = 4; k < 8; k++)
            wr_reg(k, $urandom_range(8'hD8, 8'h01));
         settle();
         `CHK("window", s3[7:0] & 8'hFC, win)
         rd_chk(2, s2 & 8'hFC);
         rd_chk(3, s3 & 8'hFC);
         rd_chk(4, m_pg[0]);
      end
      @(posedge ref_clk_i);
      m1 <= 1'b1;
      for (int k = 0; k < 4; k++)
         wr_reg(k + 4, ed[k]);
      settle();
      wr_reg(0, 8'h1D);
      wr_reg(1, 8'h5A);
      h.acc(1'b1, h.base, 8'h00, q, qo);
      `CHK("rsvd_wr", 8'h1D, q)
      foreach (ro[i])
      begin
         h.acc(1'b1, h.base + ro[i], 8'h00, q, qo);
         `CHK("closed_oe", 1'b0, qo)
      end
      do_reset(1'b1);
      h.init();
      h.acc(1'b0, 10'h0EC, 8'h05, q, qo);
      wr_reg(5, 8'h64);
      settle();
      wr_reg(6, 8'h33);
      @(posedge ref_clk_i);
      ce <= 1'b0;
      repeat (10) @(posedge ref_clk_i);
      @(negedge ref_clk_i);
      `CHK("frozen_vld", 1'b0, vld[2])
      `CHK("frozen_cfg", 1'b1, cfg)
      @(posedge ref_clk_i);
      ce <= 1'b1;
      settle();
      print_verdict();
   end
endmodule : tb_top
